// file: include/plrc_pkg.sv
// package for the link-drop / mac-interface / 100base-tx configuration register bank
// assumes an apb master with 32-bit data; registers are 16 bits in the low half-word
package plrc_pkg;

  // register indices; byte address is four times the index
  localparam logic [7:0] LINK_DROP_CONFIG_IDX = 8'h2D;
  localparam logic [7:0] CONFIG_FOUR_IDX = 8'h31;
  localparam logic [7:0] MAC_IF_CONTROL_IDX = 8'h32;
  localparam logic [7:0] MAC_IF_CONTROL_TWO_IDX = 8'h33;
  localparam logic [7:0] FAST_ETHERNET_CONFIG_IDX = 8'h43;

  // link drop config fields
  localparam int QLL_ENABLE_BIT = 15;
  localparam int QLL_GIGABIT_BIT = 14;
  localparam int CAUSE_LSB = 8;
  localparam int NUM_SOURCES = 5;

  // reset values
  localparam logic [15:0] LINK_DROP_CONFIG_RST = 16'h0000;
  localparam logic [15:0] CONFIG_FOUR_RST = 16'h0010;
  localparam logic [15:0] MAC_IF_CONTROL_RST = 16'h00D0;
  localparam logic [15:0] MAC_IF_CONTROL_TWO_RST = 16'h0000;
  localparam logic [15:0] FAST_ETHERNET_CONFIG_RST = 16'h07A0;

  // writable bits per register; all others hold their reset value, except link drop config bits 12:8, which read the cause flags
  localparam logic [15:0] LINK_DROP_CONFIG_WMASK = 16'hC01F;
  localparam logic [15:0] CONFIG_FOUR_WMASK = 16'h0181;
  localparam logic [15:0] MAC_IF_CONTROL_WMASK = 16'h00FB;
  localparam logic [15:0] MAC_IF_CONTROL_TWO_WMASK = 16'h0010;
  localparam logic [15:0] FAST_ETHERNET_CONFIG_WMASK = 16'h0FFF;

  // field positions used by the outputs
  localparam int MIRROR_BIT = 0;
  localparam int IF_ENABLE_BIT = 7;
  localparam int RX_HALF_LSB = 5;
  localparam int TX_HALF_LSB = 3;
  localparam int TX_CLK_SHIFT_BIT = 1;
  localparam int RX_CLK_SHIFT_BIT = 0;
  localparam int ASYNC_SKIP_BIT = 4;
  localparam int TIMEOUT_OFF_BIT = 11;
  localparam int RECOVERY_LSB = 7;
  localparam int FORCE_LINK_BIT = 6;
  localparam int TERNARY_BIT = 5;
  localparam int GAP_BIT = 4;
  localparam int DECODER_SKIP_BIT = 3;
  localparam int SCRAMBLER_OFF_BIT = 2;
  localparam int ODD_NIBBLE_BIT = 1;
  localparam int EARLY_VALID_BIT = 0;

  // timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int PKT_TIMEOUT_US = 1500;
  localparam int PKT_TIMEOUT_CYC = (PKT_TIMEOUT_US * 1000) / CLK_PERIOD_NS;
  localparam int MS_NS = 1000000;
  localparam int MS_CYC = MS_NS / CLK_PERIOD_NS;

  typedef struct packed {
    logic quick_link_loss_enable;
    logic quick_link_loss_gigabit;
    logic [4:0] link_loss_source_enables;
    logic port_mirror;
    logic mac_if_enable;
    logic [1:0] rx_fifo_half_level;
    logic [1:0] tx_fifo_half_level;
    logic tx_clk_shift;
    logic rx_clk_shift;
    logic async_fifo_skip;
    logic unscramble_timeout_off;
    logic [3:0] unscramble_recovery_time;
    logic force_link_good;
    logic enhanced_ternary_detect;
    logic enhanced_gap_detect;
    logic rx_block_decoder_skip;
    logic scrambler_off;
    logic odd_nibble_detect;
    logic early_rx_valid;
  } plrc_cfg_s;

  typedef struct packed {
    logic rx_cut;
    logic unscramble_recovering;
  } plrc_rx_status_s;

endpackage

// file: rtl/plrc_regs.sv
// register bank for link drop, mac interface and 100base-tx options, apb slave
// assumes single clock pclk, drop events and unscramble_unlock are synchronous one-cycle inputs, rx_pkt_active is a synchronous level
//
// Our own choice: register access over APB.
`timescale 1ns/100ps
module plrc_regs #(
  parameter int ADDR_W = 12,
  parameter int PKT_TIMEOUT_CYCLES = plrc_pkg::PKT_TIMEOUT_CYC,
  parameter int MS_CYCLES = plrc_pkg::MS_CYC
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // link monitor events
  input wire logic [4:0] drop_event,
  // 100base-tx receive state
  input wire logic rx_pkt_active,
  input wire logic unscramble_unlock,
  // configuration and status toward the datapath
  output plrc_pkg::plrc_cfg_s cfg,
  output logic [4:0] link_loss_cause_flags,
  output plrc_pkg::plrc_rx_status_s rx_status
);

  localparam int TO_W = $clog2(PKT_TIMEOUT_CYCLES + 1);
  localparam int MS_W = $clog2(MS_CYCLES + 1);

  if (ADDR_W < 10 || ADDR_W > 32) begin : g_bad_addr
    $error("plrc_regs: ADDR_W must be 10..32");
  end
  if (PKT_TIMEOUT_CYCLES < 1 || MS_CYCLES < 1) begin : g_bad_time
    $error("plrc_regs: timing counts must be at least one");
  end

  function automatic logic [ADDR_W-1:0] byte_addr(input logic [7:0] idx);
    byte_addr = ADDR_W'({idx, 2'b00});
  endfunction

  function automatic logic [15:0] merge(input logic [15:0] old_v, input logic [15:0] wd,
                                        input logic [1:0] strb, input logic [15:0] wmask);
    logic [15:0] lanes;
    lanes = {{8{strb[1]}}, {8{strb[0]}}} & wmask;
    merge = (old_v & ~lanes) | (wd & lanes);
  endfunction

  logic [15:0] ldc_q;
  logic [15:0] cf4_q;
  logic [15:0] mic_q;
  logic [15:0] mic2_q;
  logic [15:0] fec_q;
  logic [4:0] flags_q;
  logic [4:0] rd_flags_q;
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;
  logic [TO_W-1:0] pkt_cnt_q;
  logic rx_cut_q;
  logic [MS_W-1:0] ms_cnt_q;
  logic [3:0] rec_ms_q;
  logic recovering_q;
  plrc_pkg::plrc_cfg_s cfg_q;

  logic setup;
  logic done;
  logic wr;
  logic hit_ldc;
  logic hit_cf4;
  logic hit_mic;
  logic hit_mic2;
  logic hit_fec;
  logic mapped;
  logic [15:0] rd_val;
  logic [4:0] drop_hit;

  assign setup = psel && !penable && !pready_q;
  // pready is registered, so the access phase always lasts exactly one cycle
  assign done = psel && penable && pready_q;
  assign wr = done && pwrite;
  assign hit_ldc = paddr == byte_addr(plrc_pkg::LINK_DROP_CONFIG_IDX);
  assign hit_cf4 = paddr == byte_addr(plrc_pkg::CONFIG_FOUR_IDX);
  assign hit_mic = paddr == byte_addr(plrc_pkg::MAC_IF_CONTROL_IDX);
  assign hit_mic2 = paddr == byte_addr(plrc_pkg::MAC_IF_CONTROL_TWO_IDX);
  assign hit_fec = paddr == byte_addr(plrc_pkg::FAST_ETHERNET_CONFIG_IDX);
  assign mapped = hit_ldc || hit_cf4 || hit_mic || hit_mic2 || hit_fec;

  // a cause latches only when its source is enabled and fast drop is armed
  assign drop_hit = drop_event & ldc_q[4:0] & {5{ldc_q[plrc_pkg::QLL_ENABLE_BIT]}};

  always_comb begin
    rd_val = 16'h0000;
    unique case (1'b1)
      hit_ldc: rd_val = {ldc_q[15:14], 1'b0, flags_q, 3'b000, ldc_q[4:0]};
      hit_cf4: rd_val = cf4_q;
      hit_mic: rd_val = mic_q;
      hit_mic2: rd_val = mic2_q;
      hit_fec: rd_val = fec_q;
      default: rd_val = 16'h0000;
    endcase
  end

  // apb answer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h00000000;
    end else begin
      pready_q <= setup;
      pslverr_q <= setup && !mapped;
      if (setup && !pwrite) begin
        prdata_q <= {16'h0000, rd_val};
      end else if (done) begin
        prdata_q <= 32'h00000000;
      end
    end
  end

  // flags shown to the reader are captured so only those are cleared afterwards
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_flags_q <= 5'h00;
    end else if (setup) begin
      rd_flags_q <= (!pwrite && hit_ldc) ? flags_q : 5'h00;
    end
  end

  // latched cause flags; a new event wins over the read clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags_q <= 5'h00;
    end else begin
      flags_q <= (flags_q & ~((done && !pwrite) ? rd_flags_q : 5'h00)) | drop_hit;
    end
  end

  // link drop config
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ldc_q <= plrc_pkg::LINK_DROP_CONFIG_RST;
    end else if (wr && hit_ldc) begin
      ldc_q <= merge(ldc_q, pwdata[15:0], pstrb[1:0],
                     plrc_pkg::LINK_DROP_CONFIG_WMASK);
    end
  end

  // config four; bits 6:1 stay at their fixed value
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cf4_q <= plrc_pkg::CONFIG_FOUR_RST;
    end else if (wr && hit_cf4) begin
      cf4_q <= merge(cf4_q, pwdata[15:0], pstrb[1:0], plrc_pkg::CONFIG_FOUR_WMASK);
    end
  end

  // mac interface control; reserved bits are outside the mask and stay zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mic_q <= plrc_pkg::MAC_IF_CONTROL_RST;
    end else if (wr && hit_mic) begin
      mic_q <= merge(mic_q, pwdata[15:0], pstrb[1:0],
                     plrc_pkg::MAC_IF_CONTROL_WMASK);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mic2_q <= plrc_pkg::MAC_IF_CONTROL_TWO_RST;
    end else if (wr && hit_mic2) begin
      mic2_q <= merge(mic2_q, pwdata[15:0], pstrb[1:0],
                      plrc_pkg::MAC_IF_CONTROL_TWO_WMASK);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fec_q <= plrc_pkg::FAST_ETHERNET_CONFIG_RST;
    end else if (wr && hit_fec) begin
      fec_q <= merge(fec_q, pwdata[15:0], pstrb[1:0],
                     plrc_pkg::FAST_ETHERNET_CONFIG_WMASK);
    end
  end

  // output copy of the fields, one cycle behind the registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      // reset copy takes enable, fifo levels, recovery time and ternary from the register reset words; all other fields reset to zero
      cfg_q <= '0;
      cfg_q.mac_if_enable <= plrc_pkg::MAC_IF_CONTROL_RST[plrc_pkg::IF_ENABLE_BIT];
      cfg_q.rx_fifo_half_level <= plrc_pkg::MAC_IF_CONTROL_RST[plrc_pkg::RX_HALF_LSB +: 2];
      cfg_q.tx_fifo_half_level <= plrc_pkg::MAC_IF_CONTROL_RST[plrc_pkg::TX_HALF_LSB +: 2];
      cfg_q.unscramble_recovery_time <=
        plrc_pkg::FAST_ETHERNET_CONFIG_RST[plrc_pkg::RECOVERY_LSB +: 4];
      cfg_q.enhanced_ternary_detect <=
        plrc_pkg::FAST_ETHERNET_CONFIG_RST[plrc_pkg::TERNARY_BIT];
    end else begin
      cfg_q.quick_link_loss_enable <= ldc_q[plrc_pkg::QLL_ENABLE_BIT];
      cfg_q.quick_link_loss_gigabit <= ldc_q[plrc_pkg::QLL_GIGABIT_BIT];
      cfg_q.link_loss_source_enables <= ldc_q[4:0];
      cfg_q.port_mirror <= cf4_q[plrc_pkg::MIRROR_BIT];
      cfg_q.mac_if_enable <= mic_q[plrc_pkg::IF_ENABLE_BIT];
      cfg_q.rx_fifo_half_level <= mic_q[plrc_pkg::RX_HALF_LSB +: 2];
      cfg_q.tx_fifo_half_level <= mic_q[plrc_pkg::TX_HALF_LSB +: 2];
      cfg_q.tx_clk_shift <= mic_q[plrc_pkg::TX_CLK_SHIFT_BIT];
      cfg_q.rx_clk_shift <= mic_q[plrc_pkg::RX_CLK_SHIFT_BIT];
      cfg_q.async_fifo_skip <= mic2_q[plrc_pkg::ASYNC_SKIP_BIT];
      cfg_q.unscramble_timeout_off <= fec_q[plrc_pkg::TIMEOUT_OFF_BIT];
      cfg_q.unscramble_recovery_time <= fec_q[plrc_pkg::RECOVERY_LSB +: 4];
      cfg_q.force_link_good <= fec_q[plrc_pkg::FORCE_LINK_BIT];
      cfg_q.enhanced_ternary_detect <= fec_q[plrc_pkg::TERNARY_BIT];
      cfg_q.enhanced_gap_detect <= fec_q[plrc_pkg::GAP_BIT];
      cfg_q.rx_block_decoder_skip <= fec_q[plrc_pkg::DECODER_SKIP_BIT];
      cfg_q.scrambler_off <= fec_q[plrc_pkg::SCRAMBLER_OFF_BIT];
      cfg_q.odd_nibble_detect <= fec_q[plrc_pkg::ODD_NIBBLE_BIT];
      cfg_q.early_rx_valid <= fec_q[plrc_pkg::EARLY_VALID_BIT];
    end
  end

  // packet length watchdog: cut reception once a packet outlasts the timeout
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pkt_cnt_q <= '0;
      rx_cut_q <= 1'b0;
    end else if (!rx_pkt_active) begin
      pkt_cnt_q <= '0;
      rx_cut_q <= 1'b0;
    end else begin
      if (pkt_cnt_q != TO_W'(PKT_TIMEOUT_CYCLES)) begin
        pkt_cnt_q <= pkt_cnt_q + 1'b1;
      end
      // disabling the timeout also releases a cut already in progress
      rx_cut_q <= !fec_q[plrc_pkg::TIMEOUT_OFF_BIT]
                  && pkt_cnt_q == TO_W'(PKT_TIMEOUT_CYCLES);
    end
  end

  // recovery window after unscramble unlock, counted in whole milliseconds
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ms_cnt_q <= '0;
      rec_ms_q <= 4'h0;
      recovering_q <= 1'b0;
    end else if (unscramble_unlock) begin
      ms_cnt_q <= '0;
      rec_ms_q <= fec_q[plrc_pkg::RECOVERY_LSB +: 4];
      recovering_q <= fec_q[plrc_pkg::RECOVERY_LSB +: 4] != 4'h0;
    end else if (recovering_q) begin
      if (ms_cnt_q == MS_W'(MS_CYCLES - 1)) begin
        ms_cnt_q <= '0;
        rec_ms_q <= rec_ms_q - 4'h1;
        recovering_q <= rec_ms_q != 4'h1;
      end else begin
        ms_cnt_q <= ms_cnt_q + 1'b1;
      end
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign cfg = cfg_q;
  assign link_loss_cause_flags = flags_q;
  assign rx_status = '{rx_cut: rx_cut_q, unscramble_recovering: recovering_q};

endmodule

// file: tb/plrc_regs_properties.sv
// port checker for the link drop / mac interface / 100base-tx register bank
// assumes it is bound to plrc_regs and sees only that module's ports
`timescale 1ns/100ps
module plrc_regs_properties #(
  parameter int ADDR_W = 12,
  parameter int PKT_TIMEOUT_CYCLES = 20,
  parameter int MS_CYCLES = 8
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // datapath side
  input wire logic [4:0] drop_event,
  input wire logic rx_pkt_active,
  input wire logic unscramble_unlock,
  input plrc_pkg::plrc_cfg_s cfg,
  input wire logic [4:0] link_loss_cause_flags,
  input plrc_pkg::plrc_rx_status_s rx_status
);
  logic rd_drop;
  logic [4:0] flags;
  assign rd_drop = pready && !pwrite && paddr == 12'h0B4;
  assign flags = link_loss_cause_flags;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_answer;
    psel && !penable |=> pready ##1 !pready;
  endproperty
  a_answer: assert property (p_answer)
    else $error("apb answer not a single cycle after setup");
  property p_ctl_zero;
    pready && !pwrite && paddr == 12'h0C8 |-> prdata[15:8] == 8'h00 && !prdata[2];
  endproperty
  a_ctl_zero: assert property (p_ctl_zero)
    else $error("reserved interface control bits read nonzero");
  property p_two_zero;
    pready && !pwrite && paddr == 12'h0CC |-> (prdata & 32'hFFFFFFEF) == 32'h00000000;
  endproperty
  a_two_zero: assert property (p_two_zero)
    else $error("reserved control two bits read nonzero");
  property p_flag_cause;
    (flags & ~$past(flags) & ~$past(drop_event)) == 5'h00;
  endproperty
  a_flag_cause: assert property (p_flag_cause)
    else $error("cause flag rose without a drop event");
  property p_flag_hold;
    flags != 5'h00 && !rd_drop |=> (flags & $past(flags)) == $past(flags);
  endproperty
  a_flag_hold: assert property (p_flag_hold)
    else $error("cause flag cleared without a read");
  property p_rx_half;
    pready && pwrite && paddr == 12'h0C8 && pstrb[0] |->
      ##2 cfg.rx_fifo_half_level == $past(pwdata[6:5], 2);
  endproperty
  a_rx_half: assert property (p_rx_half)
    else $error("rx half level output does not follow write");
  property p_cut;
    $rose(rx_pkt_active) && !cfg.unscramble_timeout_off |->
      !rx_status.rx_cut [*8] ##[10:16] rx_status.rx_cut;
  endproperty
  a_cut: assert property (p_cut)
    else $error("long packet cut at wrong time");
  property p_cut_idle;
    !rx_pkt_active |=> !rx_status.rx_cut;
  endproperty
  a_cut_idle: assert property (p_cut_idle)
    else $error("cut held without a packet");
  property p_recover;
    unscramble_unlock && cfg.unscramble_recovery_time == 4'h1 |=>
      rx_status.unscramble_recovering [*8] ##[1:2] !rx_status.unscramble_recovering;
  endproperty
  a_recover: assert property (p_recover)
    else $error("recovery window length wrong");
endmodule

bind plrc_regs plrc_regs_properties #(.ADDR_W(ADDR_W),
  .PKT_TIMEOUT_CYCLES(PKT_TIMEOUT_CYCLES), .MS_CYCLES(MS_CYCLES)) u_props (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .drop_event(drop_event), .rx_pkt_active(rx_pkt_active),
  .unscramble_unlock(unscramble_unlock), .cfg(cfg),
  .link_loss_cause_flags(link_loss_cause_flags), .rx_status(rx_status));

// file: tb/plrc_apb_host.sv
// apb host model for the register bank
// assumes xfer is entered just after a rising edge, never twice in one step
`timescale 1ns/100ps
module plrc_apb_host (
  // clock
  input wire logic pclk,
  // apb master
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [11:0] paddr,
  output logic [31:0] pwdata,
  output logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h00000000;
    pstrb = 4'h0;
  end
  task automatic xfer(input logic w, input logic [11:0] a, input logic [15:0] d,
      input logic [3:0] s, output logic [31:0] rd, output logic err);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {16'h0000, d};
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // released address and data lines flip so a stale value cannot pass for a held one
    paddr <= ~a;
    pwdata <= ~{16'h0000, d};
  endtask
endmodule

// file: tb/test_phy_link_drop_rgmii_config_regs.sv
// self-checking bench for the register bank
// assumes the apb host model and the bound property checker
`timescale 1ns/100ps
module test_phy_link_drop_rgmii_config_regs;
  typedef struct packed {
    logic [11:0] a;
    logic [15:0] d;
    logic [3:0] s;
    logic [15:0] e;
    logic x;
  } plrc_row_s;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
  logic rx_pkt_active, unscramble_unlock;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] pstrb;
  logic [4:0] drop_event, flags;
  plrc_pkg::plrc_cfg_s cfg;
  plrc_pkg::plrc_rx_status_s rx_status;
  int errors, samples_checked;
  plrc_row_s rows [9] = '{
    '{12'h0B4, 16'hFFFF, 4'hF, 16'hC01F, 1'b0},
    '{12'h0C4, 16'hFFFF, 4'hF, 16'h0191, 1'b0},
    '{12'h0C8, 16'hFFFF, 4'hF, 16'h00FB, 1'b0},
    '{12'h0CC, 16'hFFFF, 4'hF, 16'h0010, 1'b0},
    '{12'h10C, 16'hFFFF, 4'hF, 16'h0FFF, 1'b0},
    '{12'h10C, 16'h0000, 4'hF, 16'h0000, 1'b0},
    '{12'h0C8, 16'h0000, 4'hF, 16'h0000, 1'b0},
    '{12'h0C8, 16'hFFFF, 4'h2, 16'h0000, 1'b0},
    '{12'h0D0, 16'hFFFF, 4'hF, 16'h0000, 1'b1}};
  plrc_regs #(.ADDR_W(12), .PKT_TIMEOUT_CYCLES(20), .MS_CYCLES(8)) dut (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .drop_event(drop_event), .rx_pkt_active(rx_pkt_active),
    .unscramble_unlock(unscramble_unlock), .cfg(cfg), .link_loss_cause_flags(flags),
    .rx_status(rx_status));
  plrc_apb_host host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr));
  always begin
    #5;
    pclk = ~pclk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [15:0] d);
    @(posedge pclk);
    host.xfer(1'b1, a, d, 4'hF, rd, er);
  endtask
  task automatic rdchk(input logic [11:0] a, input logic [15:0] e);
    @(posedge pclk);
    host.xfer(1'b0, a, 16'h0000, 4'hF, rd, er);
    chk(rd, {16'h0000, e}, "read data");
  endtask
  task automatic pulse(input logic [4:0] v);
    @(posedge pclk);
    drop_event <= v;
    @(posedge pclk);
    drop_event <= 5'h00;
    repeat (2) @(posedge pclk);
  endtask
  task automatic complete_run;
    $display("checks %0d errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  initial begin
    #200000;
    errors++;
    complete_run();
  end
  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    drop_event = 5'h00;
    rx_pkt_active = 1'b0;
    unscramble_unlock = 1'b0;
    errors = 0;
    samples_checked = 0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    rdchk(12'h0B4, 16'h0000);
    rdchk(12'h0C4, 16'h0010);
    rdchk(12'h0C8, 16'h00D0);
    rdchk(12'h0CC, 16'h0000);
    rdchk(12'h10C, 16'h07A0);
    foreach (rows[i]) begin
      @(posedge pclk);
      host.xfer(1'b1, rows[i].a, rows[i].d, rows[i].s, rd, er);
      chk({31'h0, er}, {31'h0, rows[i].x}, "write response");
      rdchk(rows[i].a, rows[i].e);
      chk({31'h0, er}, {31'h0, rows[i].x}, "read response");
    end
    wr(12'h10C, 16'h0A55);
    wr(12'h0C8, 16'h00AA);
    repeat (2) @(posedge pclk);
    chk({20'h0, cfg[11:0]}, 32'h00000A55, "100base-tx outputs");
    chk({25'h0, cfg.mac_if_enable, cfg.rx_fifo_half_level, cfg.tx_fifo_half_level,
      cfg.tx_clk_shift, cfg.rx_clk_shift}, 32'h00000056, "interface outputs");
    chk({23'h0, cfg.quick_link_loss_enable, cfg.quick_link_loss_gigabit,
      cfg.link_loss_source_enables, cfg.port_mirror, cfg.async_fifo_skip},
      32'h000001FF, "drop and mirror outputs");
    wr(12'h0B4, 16'h801F);
    pulse(5'h15);
    chk({27'h0, flags}, 32'h00000015, "cause flags");
    rdchk(12'h0B4, 16'h951F);
    rdchk(12'h0B4, 16'h801F);
    wr(12'h0B4, 16'h401F);
    pulse(5'h1F);
    chk({27'h0, flags}, 32'h00000000, "flags with master off");
    wr(12'h0B4, 16'hC001);
    pulse(5'h1F);
    chk({27'h0, flags}, 32'h00000001, "flags with one source");
    wr(12'h10C, 16'h0000);
    // let the timeout-off copy settle before the packet starts
    @(posedge pclk);
    rx_pkt_active <= 1'b1;
    repeat (15) @(posedge pclk);
    chk({31'h0, rx_status.rx_cut}, 32'h0, "early cut");
    repeat (10) @(posedge pclk);
    chk({31'h0, rx_status.rx_cut}, 32'h1, "missing cut");
    wr(12'h10C, 16'h0800);
    repeat (2) @(posedge pclk);
    chk({31'h0, rx_status.rx_cut}, 32'h0, "cut while disabled");
    rx_pkt_active <= 1'b0;
    wr(12'h10C, 16'h0080);
    @(posedge pclk);
    unscramble_unlock <= 1'b1;
    @(posedge pclk);
    unscramble_unlock <= 1'b0;
    repeat (2) @(posedge pclk);
    chk({31'h0, rx_status.unscramble_recovering}, 32'h1, "no recovery");
    repeat (10) @(posedge pclk);
    chk({31'h0, rx_status.unscramble_recovering}, 32'h0, "long recovery");
    presetn <= 1'b0;
    @(posedge pclk);
    chk({4'h0, cfg}, 32'h000D07A0, "outputs in reset");
    chk({25'h0, flags, rx_status}, 32'h00000000, "status in reset");
    chk({30'h0, pready, pslverr}, 32'h00000000, "apb in reset");
    presetn <= 1'b1;
    rdchk(12'h0C8, 16'h00D0);
    rdchk(12'h0B4, 16'h0000);
    complete_run();
  end
endmodule
